// [include/pscc_cfg.svh]
`ifndef PSCC_CFG_SVH
`define PSCC_CFG_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define PSCC_CLK_KHZ 20000
`define PSCC_PREARM_MS 8000
`define PSCC_LCB_MS 8000
`define PSCC_CONTACT_MS 50
`define PSCC_BAR_DEG_MS 100
`define PSCC_CNT_W 28

// ----------------------------------------------------------------------
// carry-up angle defaults, degrees
// ----------------------------------------------------------------------
`define PSCC_CARRY_NO_CURTAIN 9'h0AA
`define PSCC_CARRY_CURTAIN 9'h095

// ----------------------------------------------------------------------
// fault codes
// ----------------------------------------------------------------------
`define PSCC_FAULT_NONE 8'h00
`define PSCC_FAULT_BAR 8'h26
`define PSCC_FAULT_USER0 8'h40

// ----------------------------------------------------------------------
// register map and bus answers
// ----------------------------------------------------------------------
`define PSCC_REG_CARRY 8'h00
`define PSCC_REG_STATUS 8'h04
`define PSCC_REG_FAULT 8'h08
`define PSCC_RESP_OKAY 2'h0
`define PSCC_RESP_DECERR 2'h3
`define PSCC_ST_OPT3 3
`define PSCC_ST_VALVE 4
`define PSCC_ST_LAMP 5
`define PSCC_ST_FAULT_LSB 8

`endif

// [include/pscc_pkg.sv]
package pscc_pkg;

    // gray codes along idle, run, continuous, stopped, bar
    typedef enum logic [2:0] {
        PSCC_IDLE = 3'h0,
        PSCC_RUN = 3'h1,
        PSCC_CONT = 3'h3,
        PSCC_STOPPED = 3'h2,
        PSCC_BAR = 3'h6
    } pscc_state_e;

    typedef enum logic [1:0] {
        PSCC_SEL_OFF = 2'h0,
        PSCC_SEL_INCH = 2'h1,
        PSCC_SEL_SINGLE = 2'h2,
        PSCC_SEL_CONT = 2'h3
    } pscc_stroke_e;

    typedef enum logic [1:0] {
        PSCC_MODE_TWOHAND = 2'h0,
        PSCC_MODE_ONEHAND = 2'h1,
        PSCC_MODE_FOOT = 2'h2
    } pscc_mode_e;

    typedef enum logic [1:0] {
        PSCC_IDX_CARRY = 2'h0,
        PSCC_IDX_STATUS = 2'h1,
        PSCC_IDX_FAULT = 2'h2,
        PSCC_IDX_NONE = 2'h3
    } pscc_reg_t;

endpackage

// [design/pscc_top.sv]
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`include "pscc_cfg.svh"

module pscc_top import pscc_pkg::*; #(
    parameter int USER_N = 4,
    parameter int CNT_W = `PSCC_CNT_W,
    parameter int PREARM_CYC = `PSCC_PREARM_MS * `PSCC_CLK_KHZ,
    parameter int LCB_CYC = `PSCC_LCB_MS * `PSCC_CLK_KHZ,
    parameter int CONTACT_CYC = `PSCC_CONTACT_MS * `PSCC_CLK_KHZ,
    parameter int BAR_DEG_CYC = `PSCC_BAR_DEG_MS * `PSCC_CLK_KHZ
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // operator devices
    input wire logic pedalNc,
    input wire logic pedalNo,
    input wire logic handNc,
    input wire logic handNo,
    input wire logic palmLeft,
    input wire logic palmRight,
    input wire logic prearmButton,
    input wire logic barSelect,
    input wire logic barOperate,
    input wire logic curtainClear,
    input wire logic faultClearButton,
    input wire logic [USER_N-1:0] userInput,
    // selectors and straps
    input wire logic [1:0] strokeSel,
    input wire logic [1:0] modeSel,
    input wire logic optionSwitch3,
    input wire logic curtainFitted,
    // press feedback
    input wire logic [8:0] crankAngle,
    input wire logic crankPulse,
    input wire logic atTop,
    input wire logic flywheelTurning,
    // valve and indicators
    output logic safetyValveDrive,
    output logic prearmLamp,
    output logic interruptedLed,
    output logic [7:0] faultCode,
    output logic pedalNcLed,
    output logic pedalNoLed,
    output logic handNcLed,
    output logic handNoLed,
    output logic barActuatorLed,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        pscc_state_e state;
        logic opt3;
        logic [8:0] carryAngle;
        logic valve;
        logic interrupted;
        logic holdMode;
        logic carryPassed;
        logic leftTop;
        logic prearmLamp;
        logic prearmPrev;
        logic [CNT_W-1:0] prearmCnt;
        logic lcbArm;
        logic lcbOpen;
        logic [CNT_W-1:0] lcbCnt;
        logic [1:0] actReady;
        logic [1:0][CNT_W-1:0] actCnt;
        logic [CNT_W-1:0] speedCnt;
        logic [7:0] faultCode;
        logic [4:0] leds;
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } pscc_regs_s;

    pscc_regs_s r;
    pscc_regs_s next_r;
    logic [1:0] actNc;
    logic [1:0] actNo;
    logic [1:0] press;
    logic [1:0] held;
    logic bothPalms;
    logic barMode;
    logic userHit;
    logic [7:0] userCode;
    logic faultSet;
    logic [7:0] faultNew;
    logic swClear;
    logic speedFault;
    logic running;

    // register index from a byte address; read and write share it
    function automatic pscc_reg_t decodeAddr(input logic [7:0] addr);
        case (addr)
            `PSCC_REG_CARRY: decodeAddr = PSCC_IDX_CARRY;
            `PSCC_REG_STATUS: decodeAddr = PSCC_IDX_STATUS;
            `PSCC_REG_FAULT: decodeAddr = PSCC_IDX_FAULT;
            default: decodeAddr = PSCC_IDX_NONE;
        endcase
    endfunction

    assign actNc = {handNc, pedalNc};
    assign actNo = {handNo, pedalNo};
    assign bothPalms = palmLeft && palmRight;
    assign barMode = barSelect && strokeSel == PSCC_SEL_INCH
        && modeSel == PSCC_MODE_TWOHAND;

    always_comb begin
        next_r = r;
        press = 2'h0;
        held = 2'h0;
        userHit = |userInput;
        userCode = `PSCC_FAULT_USER0;
        faultSet = 1'b0;
        faultNew = `PSCC_FAULT_NONE;
        swClear = 1'b0;
        speedFault = 1'b0;
        running = r.state == PSCC_RUN || r.state == PSCC_CONT
            || r.state == PSCC_BAR;
        for (int i = USER_N - 1; i >= 0; i--) begin
            if (userInput[i]) begin
                userCode = 8'(`PSCC_FAULT_USER0 + i);
            end
        end

        // --------------------------------------------------------------
        // contact supervision: both contacts must swap quickly
        // --------------------------------------------------------------
        for (int i = 0; i < 2; i++) begin
            held[i] = !actNc[i] && actNo[i];
            if (actNc[i] && !actNo[i]) begin
                next_r.actReady[i] = 1'b1;
                next_r.actCnt[i] = '0;
            end else if (held[i]) begin
                press[i] = r.actReady[i];
                next_r.actReady[i] = 1'b0;
            end else if (r.actReady[i]) begin
                // stuck between contacts too long: wait for release
                if (r.actCnt[i] == CNT_W'(CONTACT_CYC - 1)) begin
                    next_r.actReady[i] = 1'b0;
                end else begin
                    next_r.actCnt[i] = r.actCnt[i] + 1'b1;
                end
            end
        end
        next_r.leds = {barOperate, handNo, handNc, pedalNo, pedalNc};

        // --------------------------------------------------------------
        // curtain-break window
        // --------------------------------------------------------------
        if (!curtainClear) begin
            next_r.lcbArm = 1'b1;
            next_r.lcbOpen = 1'b0;
        end else if (r.lcbArm) begin
            next_r.lcbArm = 1'b0;
            next_r.lcbOpen = 1'b1;
            next_r.lcbCnt = CNT_W'(LCB_CYC - 1);
        end else if (r.lcbOpen) begin
            if (r.lcbCnt == '0) begin
                next_r.lcbOpen = 1'b0;
            end else begin
                next_r.lcbCnt = r.lcbCnt - 1'b1;
            end
        end

        // --------------------------------------------------------------
        // barring speed: spacing of crank pulses
        // --------------------------------------------------------------
        if (r.state != PSCC_BAR) begin
            next_r.speedCnt = '1;
        end else if (crankPulse) begin
            speedFault = r.speedCnt < CNT_W'(BAR_DEG_CYC - 1);
            next_r.speedCnt = '0;
        end else if (r.speedCnt != '1) begin
            next_r.speedCnt = r.speedCnt + 1'b1;
        end

        // --------------------------------------------------------------
        // stroke sequencing
        // --------------------------------------------------------------
        if (!atTop) begin
            next_r.leftTop = 1'b1;
        end
        case (r.state)
            PSCC_IDLE: begin
                next_r.leftTop = 1'b0;
                next_r.carryPassed = 1'b0;
                if (r.faultCode != `PSCC_FAULT_NONE) begin
                    next_r.state = PSCC_IDLE;
                end else if (barMode && barOperate) begin
                    next_r.state = PSCC_BAR;
                    if (flywheelTurning) begin
                        faultSet = 1'b1;
                        faultNew = `PSCC_FAULT_BAR;
                    end
                end else if (strokeSel == PSCC_SEL_CONT
                        && modeSel == PSCC_MODE_FOOT) begin
                    if (r.prearmLamp && press[0]) begin
                        next_r.state = PSCC_CONT;
                        next_r.prearmLamp = 1'b0;
                    end
                end else if (strokeSel == PSCC_SEL_SINGLE
                        && modeSel == PSCC_MODE_FOOT && press[0]) begin
                    next_r.state = PSCC_RUN;
                    next_r.holdMode = r.opt3;
                end else if (strokeSel == PSCC_SEL_SINGLE
                        && modeSel == PSCC_MODE_ONEHAND && press[1]
                        && (!r.opt3 || r.lcbOpen)) begin
                    next_r.state = PSCC_RUN;
                    next_r.holdMode = 1'b0;
                    next_r.lcbOpen = 1'b0;
                end
            end
            PSCC_RUN: begin
                if (crankAngle >= r.carryAngle) begin
                    next_r.carryPassed = 1'b1;
                end
                if (r.holdMode && !r.carryPassed && !held[0]) begin
                    next_r.state = PSCC_STOPPED;
                end else if (r.leftTop && atTop) begin
                    next_r.state = PSCC_IDLE;
                end
            end
            PSCC_CONT: begin
                if (r.leftTop && atTop) begin
                    if (held[0]) begin
                        next_r.leftTop = 1'b0;
                    end else begin
                        next_r.state = PSCC_IDLE;
                    end
                end
            end
            PSCC_BAR: begin
                if (speedFault) begin
                    next_r.state = PSCC_IDLE;
                    faultSet = 1'b1;
                    faultNew = `PSCC_FAULT_BAR;
                end else if (!barOperate) begin
                    next_r.state = PSCC_IDLE;
                end
            end
            PSCC_STOPPED: begin
                // two-hand maintained return; requests are not looked at
                if (r.leftTop && atTop) begin
                    next_r.state = PSCC_IDLE;
                end
            end
            default: begin
                next_r.state = PSCC_IDLE;
            end
        endcase

        // any running state stops on a user input; run and continuous also on a blocked curtain when one is fitted
        if (running && userHit) begin
            next_r.state = r.state == PSCC_BAR ? PSCC_IDLE
                : PSCC_STOPPED;
            faultSet = 1'b1;
            faultNew = userCode;
        end else if ((r.state == PSCC_RUN || r.state == PSCC_CONT)
                && curtainFitted && !curtainClear) begin
            next_r.state = PSCC_STOPPED;
        end

        // --------------------------------------------------------------
        // pre-arm lamp window
        // --------------------------------------------------------------
        if (prearmButton && !r.prearmPrev) begin
            next_r.prearmLamp = 1'b1;
            next_r.prearmCnt = CNT_W'(PREARM_CYC - 1);
        end else if (r.prearmLamp) begin
            if (r.prearmCnt == '0) begin
                next_r.prearmLamp = 1'b0;
            end else begin
                next_r.prearmCnt = r.prearmCnt - 1'b1;
            end
        end
        next_r.prearmPrev = prearmButton;

        // --------------------------------------------------------------
        // axi4-lite write: address and data in either order
        // --------------------------------------------------------------
        if (s_axi_awvalid && r.awready) begin
            next_r.awHeld = 1'b1;
            next_r.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready) begin
            next_r.wHeld = 1'b1;
            next_r.wData = s_axi_wdata;
            next_r.wStrb = s_axi_wstrb;
        end
        if (r.awHeld && r.wHeld && !r.bvalid) begin
            next_r.awHeld = 1'b0;
            next_r.wHeld = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = `PSCC_RESP_OKAY;
            case (decodeAddr(r.awAddr))
                PSCC_IDX_CARRY: begin
                    if (r.wStrb[0]) begin
                        next_r.carryAngle[7:0] = r.wData[7:0];
                    end
                    if (r.wStrb[1]) begin
                        next_r.carryAngle[8] = r.wData[8];
                    end
                end
                PSCC_IDX_STATUS: begin
                    next_r.bresp = `PSCC_RESP_OKAY;
                end
                PSCC_IDX_FAULT: begin
                    swClear = r.wStrb[0] && r.wData[0];
                end
                default: begin
                    next_r.bresp = `PSCC_RESP_DECERR;
                end
            endcase
        end else if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end
        next_r.awready = !next_r.awHeld && !next_r.bvalid;
        next_r.wready = !next_r.wHeld && !next_r.bvalid;

        // --------------------------------------------------------------
        // axi4-lite read
        // --------------------------------------------------------------
        if (s_axi_arvalid && r.arready) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = `PSCC_RESP_OKAY;
            next_r.rdata = '0;
            case (decodeAddr(s_axi_araddr))
                PSCC_IDX_CARRY: next_r.rdata[8:0] = r.carryAngle;
                PSCC_IDX_STATUS: begin
                    next_r.rdata[2:0] = r.state;
                    next_r.rdata[`PSCC_ST_OPT3] = r.opt3;
                    next_r.rdata[`PSCC_ST_VALVE] = r.valve;
                    next_r.rdata[`PSCC_ST_LAMP] = r.prearmLamp;
                    next_r.rdata[`PSCC_ST_FAULT_LSB +: 8] = r.faultCode;
                end
                PSCC_IDX_FAULT: next_r.rdata = '0;
                default: next_r.rresp = `PSCC_RESP_DECERR;
            endcase
        end else if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
        next_r.arready = !next_r.rvalid;

        // a new fault wins over a clear in the same cycle
        if (faultSet) begin
            next_r.faultCode = faultNew;
        end else if (faultClearButton || swClear) begin
            next_r.faultCode = `PSCC_FAULT_NONE;
        end

        // valve follows the state just chosen
        case (next_r.state)
            PSCC_RUN, PSCC_CONT: next_r.valve = 1'b1;
            PSCC_BAR: next_r.valve = barOperate;
            PSCC_STOPPED: next_r.valve = bothPalms
                && next_r.faultCode == `PSCC_FAULT_NONE;
            default: next_r.valve = 1'b0;
        endcase
        next_r.interrupted = next_r.state == PSCC_STOPPED;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            r <= '0;
            r.state <= PSCC_IDLE;
            r.opt3 <= optionSwitch3;
            r.carryAngle <= curtainFitted ? `PSCC_CARRY_CURTAIN
                : `PSCC_CARRY_NO_CURTAIN;
            r.faultCode <= `PSCC_FAULT_NONE;
            r.speedCnt <= '1;
            r.leds <= 5'h01;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign safetyValveDrive = r.valve;
    assign prearmLamp = r.prearmLamp;
    assign interruptedLed = r.interrupted;
    assign faultCode = r.faultCode;
    assign {barActuatorLed, handNoLed, handNcLed, pedalNoLed, pedalNcLed} =
        r.leds;
    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rresp = r.rresp;
    assign s_axi_rdata = r.rdata;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    option_hold_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        1'b1 |=> $stable(r.opt3)) else $error("option latch changed");
    hold_release_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        r.state == PSCC_RUN && r.holdMode && !r.carryPassed
        && !(!pedalNc && pedalNo) |=> r.state == PSCC_STOPPED)
        else $error("hold-to-run release did not stop");
    stopped_block_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        r.state == PSCC_STOPPED && !atTop |=> r.state == PSCC_STOPPED)
        else $error("left interrupted stroke early");
    cont_entry_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        r.state == PSCC_CONT && $past(r.state) == PSCC_IDLE
        |-> $past(r.prearmLamp)) else $error("continuous without pre-arm");
    cont_end_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        r.state == PSCC_CONT && r.leftTop && atTop && pedalNc && !userHit
        && !(curtainFitted && !curtainClear)
        |=> r.state == PSCC_IDLE && !safetyValveDrive)
        else $error("continuous did not stop at top");
    // a continuous start uses up the lamp, so it may drop then
    prearm_lamp_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        $rose(prearmButton) |=> prearmLamp
        ##1 (prearmLamp || r.state == PSCC_CONT) [*2])
        else $error("pre-arm lamp not lit");
    bar_valve_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        r.state == PSCC_BAR && !barOperate |=> !safetyValveDrive)
        else $error("bar valve held after release");
    bar_fault_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        r.state == PSCC_IDLE && r.faultCode == `PSCC_FAULT_NONE && barMode
        && barOperate && flywheelTurning && !userHit
        |=> faultCode == `PSCC_FAULT_BAR && r.state == PSCC_BAR)
        else $error("bar press while turning gave no fault");
    user_stop_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (r.state == PSCC_RUN || r.state == PSCC_CONT) && userHit
        |=> r.state == PSCC_STOPPED && !safetyValveDrive
        && faultCode == $past(userCode)) else $error("user input ignored");

endmodule

// [tb/pscc_press_model.sv]
// ----------------------------------------------------------------------
// crank model: one degree per cycle while the valve is energized
// ----------------------------------------------------------------------
module pscc_press_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // valve in, feedback out
    input wire logic safetyValveDrive,
    output logic [8:0] crankAngle,
    output logic crankPulse,
    output logic atTop
);
    timeunit 1ns;
    timeprecision 1ns;
    // fast on purpose: barring at this rate is always too quick
    always @(posedge clk_sys) begin
        if (reset) begin
            crankAngle <= 9'h000;
        end else if (safetyValveDrive) begin
            crankAngle <= (crankAngle == 9'h167) ? 9'h000 : crankAngle + 9'h001;
        end
        crankPulse <= safetyValveDrive && !reset;
    end
    assign atTop = crankAngle < 9'h005;
endmodule

// [tb/pscc_top_tb.sv]
module pscc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pscc_pkg::*;
    logic clk_sys = 1'b0, reset = 1'b1, pedalNc = 1'b1, pedalNo = 1'b0;
    logic handNc = 1'b1, handNo = 1'b0, palmLeft = 1'b0, palmRight = 1'b0;
    logic prearmButton = 1'b0, barSelect = 1'b0, barOperate = 1'b0;
    logic curtainClear = 1'b1, faultClearButton = 1'b0, curtainFitted = 1'b0;
    logic flywheelTurning = 1'b0, optionSwitch3 = 1'b0, s_axi_bready = 1'b0;
    logic [3:0] userInput = 4'h0, s_axi_wstrb = 4'hF;
    logic [1:0] strokeSel = 2'h2, modeSel = 2'h2, r, s_axi_bresp, s_axi_rresp;
    logic [8:0] crankAngle;
    logic crankPulse, atTop, safetyValveDrive, prearmLamp, interruptedLed;
    logic pedalNcLed, pedalNoLed, handNcLed, handNoLed, barActuatorLed;
    logic [7:0] faultCode, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, v;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    int miscompares = 0, samples_checked = 0, cyc = 0, i;
    pscc_top #(.PREARM_CYC(50), .LCB_CYC(50), .CONTACT_CYC(5),
        .BAR_DEG_CYC(10)) dut (.*);
    pscc_press_model press (.clk_sys(clk_sys), .reset(reset),
        .safetyValveDrive(safetyValveDrive), .crankAngle(crankAngle),
        .crankPulse(crankPulse), .atTop(atTop));
    always #25 clk_sys = !clk_sys;
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("miscompares %0d samples_checked %0d", miscompares,
            samples_checked);
        if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        s_axi_awaddr <= a;
        s_axi_wdata <= w;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic pd(input logic on, input int n);
        pedalNc <= !on;
        pedalNo <= on;
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wv(input logic lv);
        for (int n = 0; n < 2000 && safetyValveDrive !== lv; n++)
            @(posedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(32'hEB81EC2A));
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rd(8'h00);
        chk(d, 32'h0AA);
        v = $urandom % 360;
        wr(8'h00, v);
        chk(r, 2'h0);
        rd(8'h00);
        chk(d, v);
        rd(8'h0C);
        chk(r, 2'h3);
        pd(1, 2);
        chk({safetyValveDrive, pedalNcLed, pedalNoLed}, 3'b101);
        pd(0, 1);
        wv(0);
        repeat (20) @(posedge clk_sys);
        chk({safetyValveDrive, atTop}, 2'b01);
        pedalNc <= 1'b0; // slow: contacts apart longer than the window
        repeat (10) @(posedge clk_sys);
        pd(1, 5);
        chk(safetyValveDrive, 0);
        pd(0, 2);
        // continuous: lamp window first, then pre-arm plus pedal
        prearmButton <= 1'b1;
        repeat (2) @(posedge clk_sys);
        prearmButton <= 1'b0;
        chk(prearmLamp, 1);
        repeat (55) @(posedge clk_sys);
        chk(prearmLamp, 0);
        strokeSel <= 2'h3;
        prearmButton <= 1'b1;
        @(posedge clk_sys);
        prearmButton <= 1'b0;
        pd(1, 400);
        chk(safetyValveDrive, 1);
        pd(0, 1);
        wv(0);
        chk(atTop, 1);
        pd(1, 4);
        chk(safetyValveDrive, 0);
        pd(0, 2);
        // one-hand stroke broken by a user input, palms finish it
        strokeSel <= 2'h2;
        modeSel <= 2'h1;
        i = $urandom % 4;
        handNc <= 1'b0;
        handNo <= 1'b1;
        repeat (20) @(posedge clk_sys);
        chk({handNcLed, handNoLed}, 2'b01);
        userInput <= 4'h1 << i;
        handNc <= 1'b1;
        handNo <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk({interruptedLed, safetyValveDrive, faultCode},
            32'h240 + i);
        rd(8'h04);
        chk(d, 32'h4002 + (i << 8));
        userInput <= 4'h0;
        handNc <= 1'b0;
        handNo <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk({safetyValveDrive, interruptedLed}, 2'b01);
        handNc <= 1'b1;
        handNo <= 1'b0;
        faultClearButton <= 1'b1;
        palmLeft <= 1'b1;
        palmRight <= 1'b1;
        wv(1);
        wv(0);
        chk({atTop, faultCode}, 9'h100);
        palmLeft <= 1'b0;
        palmRight <= 1'b0;
        faultClearButton <= 1'b0;
        // barring with the flywheel still turning, then too fast with it stopped
        {strokeSel, modeSel, barSelect} <= 5'b01001;
        flywheelTurning <= 1'b1;
        barOperate <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk({safetyValveDrive, barActuatorLed, faultCode}, 10'h326);
        barOperate <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk({safetyValveDrive, faultCode}, 9'h026);
        wr(8'h08, 32'h1);
        chk(faultCode, 8'h00);
        flywheelTurning <= 1'b0;
        barOperate <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk(safetyValveDrive, 1);
        repeat (3) @(posedge clk_sys);
        chk({safetyValveDrive, faultCode}, 9'h026);
        barOperate <= 1'b0;
        // option 3 on needs a fresh reset: hold-to-run, then curtain break
        {strokeSel, modeSel, barSelect} <= 5'b10100;
        optionSwitch3 <= 1'b1;
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        pd(1, 20);
        pd(0, 3);
        chk({safetyValveDrive, interruptedLed}, 2'b01);
        palmLeft <= 1'b1;
        palmRight <= 1'b1;
        wv(1);
        wv(0);
        chk({interruptedLed, atTop}, 2'b01);
        palmLeft <= 1'b0;
        palmRight <= 1'b0;
        pd(1, 200);
        pd(0, 1);
        chk(safetyValveDrive, 1);
        wv(0);
        chk({interruptedLed, atTop}, 2'b01);
        modeSel <= 2'h1;
        handNc <= 1'b0;
        handNo <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(safetyValveDrive, 0);
        handNc <= 1'b1;
        handNo <= 1'b0;
        curtainClear <= 1'b0;
        repeat (2) @(posedge clk_sys);
        curtainClear <= 1'b1;
        repeat (3) @(posedge clk_sys);
        handNc <= 1'b0;
        handNo <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk(safetyValveDrive, 1);
        report_and_stop();
    end
endmodule
